// >>> common/gsr_pkg.sv
// Constants and types shared by both ends of the gyro SPI readout link.
// Behaviour
// R1: Sync enabled and hold low stop conversions.
// R2: Conversion restarts at hold input rising edge.
// R3: All self-check inputs high shift rate output.
// R4: Far end keeps self-check inputs low normally.
// R5: Temperature is offset binary, 25 C mid-scale.
// R6: Command register write-only; reserved ranges unused.
// R7: Command byte: bit7 zero, bit6 read, address.
// R8: Rate result 0x08, temperature result 0x0A, read-only.
// R9: Pin control: 0011, bit3 mode, 00, sync bit.
// R10: Pin control bit3 picks all-or-any data-ready.
// R11: Rate setup 0000, enable bit3, then 010.
// R12: Temperature setup has the same layout.
// R13: Both conversion-time registers hold 00000101.
// R14: Resolution: 001000, bit1 selects 24-bit, bit0 zero.
// R15: Traffic in bytes; command byte first.
// R16: Result read MSB first, three or two bytes.
// R17: Result read releases data-ready; busy sample dropped.
// R18: Reserved writes ignored, reserved reads give zero.
// R19: A started read shows one consistent sample.
package gsr_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 40;
  localparam int HALF_NS = 320;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHASE_NS = 43860;
  localparam int PHASE_CYC = PHASE_NS / CLK_NS;

  // ****************************************************************
  // Device register map and fields
  // ****************************************************************
  localparam logic [5:0] ADR_CTL = 6'h00;
  localparam logic [5:0] ADR_PIN = 6'h01;
  localparam logic [5:0] ADR_RATE = 6'h08;
  localparam logic [5:0] ADR_TEMP = 6'h0A;
  localparam logic [5:0] ADR_GCS = 6'h28;
  localparam logic [5:0] ADR_TCS = 6'h2A;
  localparam logic [5:0] ADR_GCT = 6'h30;
  localparam logic [5:0] ADR_TCT = 6'h32;
  localparam logic [5:0] ADR_RES = 6'h38;
  localparam int CB_ZERO = 7;
  localparam int CB_RD = 6;
  localparam int PIN_ALL = 3;
  localparam int PIN_SYNC = 0;
  localparam int CS_EN = 3;
  localparam int RES_24 = 1;
  localparam logic [7:0] PIN_RST = 8'h30;
  localparam logic [7:0] CS_RST = 8'h02;
  localparam logic [7:0] CT_RST = 8'h05;
  localparam logic [7:0] RES_RST = 8'h22;
  localparam logic [23:0] MID_CODE = 24'h800000;
  localparam logic [23:0] TEST_SHIFT_DEF = 24'h010000;

  // ****************************************************************
  // Controller register map (AXI4-Lite)
  // ****************************************************************
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_RXD = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam int CMD_WB = 8;
  localparam int CMD_NR = 16;
  localparam int STAT_DONE = 0;
  localparam int STAT_RDY = 1;
  localparam int STAT_BUSY = 2;
  localparam logic [2:0] CFG_RST = 3'h1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    D_IDLE = 2'h0,
    D_CMD = 2'h1,
    D_WDAT = 2'h3,
    D_RDAT = 2'h2
  } gsr_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LEAD = 3'h1,
    H_LOW = 3'h3,
    H_HIGH = 3'h2,
    H_TAIL = 3'h6
  } gsr_hst_t;

endpackage : gsr_pkg

// >>> common/gsr_spi_if.sv
// Serial link and side pins between the sensor and its controller.
`timescale 1ns/1ps
interface gsr_spi_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic rdy_n;
  logic hold_n;
  logic [1:0] self_check_inputs;

  modport dev (
    input sclk, input cs_n, input sdi, output sdo,
    output rdy_n, input hold_n, input self_check_inputs
  );
  modport host (
    output sclk, output cs_n, output sdi, input sdo,
    input rdy_n, output hold_n, output self_check_inputs
  );
endinterface : gsr_spi_if

// >>> hdl/gsr_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module gsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // Stage one is read only by stage two, to keep metastability contained.
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit moves only once stages two and three agree.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (rst) begin
        q[i] <= INIT[i];
      end else if (s2_ff[i] == s3_ff[i]) begin
        q[i] <= s3_ff[i];
      end
    end
  end
endmodule : gsr_sync

// >>> hdl/gsr_dev.sv
// Sensor end: serial register file, conversions and data-ready pin.
`timescale 1ns/1ps
module gsr_dev
  import gsr_pkg::*;
#(
  parameter int CONV_CYC = PHASE_CYC,
  parameter logic [23:0] TEST_SHIFT = TEST_SHIFT_DEF
) (
  input wire logic clock,
  input wire logic rst,
  gsr_spi_if.dev spi,
  input wire logic [23:0] rate_in,
  input wire logic [23:0] temp_in,
  output logic self_test,
  output logic converting
);

  // ****************************************************************
  // Pin inputs
  // ****************************************************************
  logic [5:0] pins_q;

  gsr_sync #(
    .W(6),
    .INIT(6'h34)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .d({spi.sclk, spi.cs_n, spi.sdi, spi.hold_n,
        spi.self_check_inputs}),
    .q(pins_q)
  );

  wire sclk_q = pins_q[5];
  wire cs_q = pins_q[4];
  wire sdi_q = pins_q[3];
  wire hold_q = pins_q[2];
  wire [1:0] chk_q = pins_q[1:0];

  // ****************************************************************
  // State
  // ****************************************************************
  gsr_dst_t state_ff;
  logic sclk_d_ff;
  logic [2:0] bit_ff;
  logic [6:0] rxb_ff;
  logic [5:0] adr_ff;
  logic ok_ff;
  logic [23:0] tx_ff;
  logic sdo_ff;
  logic [7:0] pin_ff;
  logic [7:0] gcs_ff;
  logic [7:0] tcs_ff;
  logic [7:0] gct_ff;
  logic [7:0] tct_ff;
  logic [7:0] res_ff;
  logic [23:0] rate_ff;
  logic [23:0] temp_ff;
  logic r_new_ff;
  logic t_new_ff;
  logic [15:0] cnt_ff;
  logic phase_ff;
  logic rdy_n_ff;
  logic st_ff;
  logic conv_ff;

  // ****************************************************************
  // Serial decode
  // ****************************************************************
  // Edges count only inside a frame; a stray clock outside is ignored.
  wire rise = ~cs_q & sclk_q & ~sclk_d_ff;
  wire fall = ~cs_q & ~sclk_q & sclk_d_ff;
  // R15: byte framing
  wire byte_end = rise & (bit_ff == 3'h7);
  wire [7:0] byte_in = {rxb_ff, sdi_q};
  wire cmd_end = byte_end & (state_ff == D_CMD);
  // R7: command byte fields
  wire rd_go = cmd_end & byte_in[CB_RD] & ~byte_in[CB_ZERO];
  wire [5:0] rd_adr = byte_in[5:0];
  wire wr_go = byte_end & (state_ff == D_WDAT) & ok_ff;

  // R6: no stored command register
  // R18: reserved writes dropped
  wire wr_pin = wr_go & (adr_ff == ADR_PIN);
  wire wr_gcs = wr_go & (adr_ff == ADR_GCS);
  wire wr_tcs = wr_go & (adr_ff == ADR_TCS);
  wire wr_gct = wr_go & (adr_ff == ADR_GCT);
  wire wr_tct = wr_go & (adr_ff == ADR_TCT);
  wire wr_res = wr_go & (adr_ff == ADR_RES);

  // R18: reserved reads zero
  wire [7:0] cfg_val =
    (rd_adr == ADR_PIN) ? pin_ff :
    (rd_adr == ADR_GCS) ? gcs_ff :
    (rd_adr == ADR_TCS) ? tcs_ff :
    (rd_adr == ADR_GCT) ? gct_ff :
    (rd_adr == ADR_TCT) ? tct_ff :
    (rd_adr == ADR_RES) ? res_ff : 8'h00;
  // R8: result registers
  wire is_res = (rd_adr == ADR_RATE) || (rd_adr == ADR_TEMP);
  wire [23:0] res_val = (rd_adr == ADR_RATE) ? rate_ff : temp_ff;
  // R14: resolution select
  wire [23:0] res_fmt =
    res_ff[RES_24] ? res_val : {res_val[23:8], 8'h00};
  wire [23:0] rd_val = is_res ? res_fmt : {cfg_val, 16'h0000};
  wire rd_res_go = rd_go & is_res;

  // ****************************************************************
  // Conversion control
  // ****************************************************************
  // R1: sync hold
  wire hold = pin_ff[PIN_SYNC] & ~hold_q;
  wire tick = cnt_ff == 16'(CONV_CYC - 1);
  // R17: busy read blocks update
  wire busy_rd = state_ff == D_RDAT;
  // R3: self-test on all high
  wire st_on = &chk_q;
  wire [23:0] shift = st_on ? TEST_SHIFT : 24'h000000;
  wire [23:0] rate_code = rate_in + MID_CODE + shift;
  // R5: temperature offset binary
  wire [23:0] temp_code = temp_in + MID_CODE;
  // R11: rate channel enable
  wire rate_upd = tick & ~phase_ff & gcs_ff[CS_EN] & ~busy_rd;
  // R12: temperature channel enable
  wire temp_upd = tick & phase_ff & tcs_ff[CS_EN] & ~busy_rd;

  // ****************************************************************
  // Frame sequencing
  // ****************************************************************
  // Chip select high aborts any frame, so a broken transfer never sticks.
  always_ff @(posedge clock) begin
    if (rst || cs_q) begin
      state_ff <= D_IDLE;
    end else begin
      unique case (state_ff)
        D_IDLE: state_ff <= D_CMD;
        D_CMD: begin
          if (cmd_end) begin
            state_ff <= byte_in[CB_RD] ? D_RDAT : D_WDAT;
          end
        end
        D_WDAT: begin
          if (byte_end) begin
            state_ff <= D_CMD;
          end
        end
        D_RDAT: state_ff <= D_RDAT;
      endcase
    end
  end

  // Clock edge history for edge detection on the filtered pin.
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_q;
    end
  end

  // Receive shifting, address capture and transmit shifting.
  always_ff @(posedge clock) begin
    if (rst || cs_q) begin
      bit_ff <= 3'h0;
      rxb_ff <= 7'h00;
      adr_ff <= 6'h00;
      ok_ff <= 1'b0;
      tx_ff <= 24'h000000;
      sdo_ff <= 1'b0;
    end else begin
      if (rise) begin
        bit_ff <= bit_ff + 3'h1;
        rxb_ff <= byte_in[6:0];
      end
      if (cmd_end) begin
        adr_ff <= byte_in[5:0];
        ok_ff <= ~byte_in[CB_ZERO];
      end
      // R19: one-shot result snapshot
      if (rd_go) begin
        tx_ff <= rd_val;
      // R16: MSB first out
      end else if (fall && busy_rd) begin
        sdo_ff <= tx_ff[23];
        tx_ff <= {tx_ff[22:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // R9: pin control store
  // R13: conversion-time store
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_ff <= PIN_RST;
      gcs_ff <= CS_RST;
      tcs_ff <= CS_RST;
      gct_ff <= CT_RST;
      tct_ff <= CT_RST;
      res_ff <= RES_RST;
    end else begin
      if (wr_pin) pin_ff <= byte_in;
      if (wr_gcs) gcs_ff <= byte_in;
      if (wr_tcs) tcs_ff <= byte_in;
      if (wr_gct) gct_ff <= byte_in;
      if (wr_tct) tct_ff <= byte_in;
      if (wr_res) res_ff <= byte_in;
    end
  end

  // ****************************************************************
  // Conversions and results
  // ****************************************************************
  // R2: restart at hold release
  always_ff @(posedge clock) begin
    if (rst || hold) begin
      cnt_ff <= 16'h0000;
      phase_ff <= 1'b0;
    end else if (tick) begin
      cnt_ff <= 16'h0000;
      phase_ff <= ~phase_ff;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // A new sample beats a read in the same cycle, so it is never lost.
  always_ff @(posedge clock) begin
    if (rst) begin
      rate_ff <= MID_CODE;
      temp_ff <= MID_CODE;
      r_new_ff <= 1'b0;
      t_new_ff <= 1'b0;
    end else begin
      if (rate_upd) rate_ff <= rate_code;
      if (temp_upd) temp_ff <= temp_code;
      // R17: read releases data-ready
      r_new_ff <= rate_upd | (r_new_ff & ~rd_res_go);
      t_new_ff <= temp_upd | (t_new_ff & ~rd_res_go);
    end
  end

  // R10: all-or-any data-ready
  always_ff @(posedge clock) begin
    if (rst) begin
      rdy_n_ff <= 1'b1;
      st_ff <= 1'b0;
      conv_ff <= 1'b0;
    end else begin
      rdy_n_ff <= pin_ff[PIN_ALL] ? ~(r_new_ff & t_new_ff)
                                  : ~(r_new_ff | t_new_ff);
      st_ff <= st_on;
      conv_ff <= ~hold;
    end
  end

  assign spi.sdo = sdo_ff;
  assign spi.rdy_n = rdy_n_ff;
  assign self_test = st_ff;
  assign converting = conv_ff;

endmodule : gsr_dev

// >>> hdl/gsr_host.sv
// Controller end: AXI4-Lite registers driving the serial link master.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module gsr_host
  import gsr_pkg::*;
#(
  parameter int HALF = HALF_CYC
) (
  input wire logic clock,
  input wire logic rst,
  gsr_spi_if.host spi,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq
);

  // ****************************************************************
  // Declarations and pin inputs
  // ****************************************************************
  logic [1:0] pin_q;
  logic aw_ff, w_ff, bv_ff, rv_ff, irq_ff, rdy_d_ff;
  logic [7:0] awa_ff;
  logic [31:0] wd_ff, rd_ff;
  logic [3:0] ws_ff;
  logic [1:0] br_ff, rr_ff, stat_ff, mask_ff;
  logic [2:0] cfg_ff;
  gsr_hst_t hs_ff;
  logic [7:0] div_ff;
  logic [5:0] bits_ff;
  logic [15:0] htx_ff;
  logic [23:0] rx_ff;
  logic sclk_ff, cs_n_ff, mosi_ff, done_ff;

  gsr_sync #(
    .W(2),
    .INIT(2'h1)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .d({spi.sdo, spi.rdy_n}),
    .q(pin_q)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire ar_take = arvalid & arready;
  wire wr_do = aw_ff & w_ff & ~bv_ff;
  wire lane = ws_ff[0];
  wire w_map = (awa_ff == A_CMD) || (awa_ff == A_CFG) ||
               (awa_ff == A_RXD) || (awa_ff == A_STAT) ||
               (awa_ff == A_MASK);
  wire wr_cmd = wr_do & lane & (awa_ff == A_CMD);
  wire wr_cfg = wr_do & lane & (awa_ff == A_CFG);
  wire wr_mask = wr_do & lane & (awa_ff == A_MASK);
  wire busy = hs_ff != H_IDLE;
  wire [31:0] rd_mux =
    (araddr == A_CFG) ? {29'h0, cfg_ff} :
    (araddr == A_RXD) ? {8'h00, rx_ff} :
    (araddr == A_STAT) ? {29'h0, busy, stat_ff} :
    (araddr == A_MASK) ? {30'h0, mask_ff} : 32'h0;
  wire r_map = (araddr == A_CMD) || (araddr == A_CFG) ||
               (araddr == A_RXD) || (araddr == A_STAT) ||
               (araddr == A_MASK);
  wire st_clr = ar_take & (araddr == A_STAT);
  wire [1:0] ev = {~pin_q[0] & rdy_d_ff, done_ff};
  // A write to the command register while busy is dropped.
  wire start = wr_cmd & ~busy;
  // R7: read bit picks length
  wire [5:0] nbits = wd_ff[CB_RD]
    ? {1'b0, wd_ff[CMD_NR+1:CMD_NR], 3'h0} + 6'h08 : 6'h10;
  wire dend = div_ff == 8'(HALF - 1);

  assign awready = ~aw_ff & ~bv_ff;
  assign wready = ~w_ff & ~bv_ff;
  assign arready = ~rv_ff;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data may arrive in either order; the answer needs both.
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bv_ff <= 1'b0;
      br_ff <= RESP_OK;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0;
      ws_ff <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_ff <= 1'b1;
        awa_ff <= awaddr;
      end
      if (w_take) begin
        w_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (wr_do) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bv_ff <= 1'b1;
        br_ff <= w_map ? RESP_OK : RESP_ERR;
      end else if (bready) begin
        bv_ff <= 1'b0;
      end
    end
  end

  // Read answers and the sticky status with its mask.
  always_ff @(posedge clock) begin
    if (rst) begin
      rv_ff <= 1'b0;
      rd_ff <= 32'h0;
      rr_ff <= RESP_OK;
      stat_ff <= 2'h0;
      mask_ff <= 2'h0;
      cfg_ff <= CFG_RST;
      irq_ff <= 1'b0;
      rdy_d_ff <= 1'b1;
    end else begin
      if (ar_take) begin
        rv_ff <= 1'b1;
        rd_ff <= rd_mux;
        rr_ff <= r_map ? RESP_OK : RESP_ERR;
      end else if (rready) begin
        rv_ff <= 1'b0;
      end
      // Set wins over the clear-on-read.
      stat_ff <= (stat_ff & ~{2{st_clr}}) | ev;
      if (wr_mask) mask_ff <= wd_ff[1:0];
      // R4: self-check held low
      if (wr_cfg) cfg_ff <= wd_ff[2:0];
      irq_ff <= |(stat_ff & mask_ff);
      rdy_d_ff <= pin_q[0];
    end
  end

  // ****************************************************************
  // Serial master
  // ****************************************************************
  // R15: whole bytes, command first
  always_ff @(posedge clock) begin
    if (rst) begin
      hs_ff <= H_IDLE;
      div_ff <= 8'h00;
      sclk_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      bits_ff <= 6'h00;
      htx_ff <= 16'h0000;
      rx_ff <= 24'h000000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      div_ff <= (hs_ff == H_IDLE || dend) ? 8'h00 : div_ff + 8'h01;
      unique case (hs_ff)
        H_IDLE: begin
          if (start) begin
            hs_ff <= H_LEAD;
            cs_n_ff <= 1'b0;
            htx_ff <= {wd_ff[7:0], wd_ff[15:8]};
            bits_ff <= nbits;
          end
        end
        H_LEAD: begin
          if (dend) begin
            hs_ff <= H_LOW;
            sclk_ff <= 1'b0;
            mosi_ff <= htx_ff[15];
            htx_ff <= {htx_ff[14:0], 1'b0};
          end
        end
        H_LOW: begin
          if (dend) begin
            hs_ff <= H_HIGH;
            sclk_ff <= 1'b1;
          end
        end
        H_HIGH: begin
          if (dend) begin
            // R16: MSB-first collection
            rx_ff <= {rx_ff[22:0], pin_q[1]};
            bits_ff <= bits_ff - 6'h01;
            if (bits_ff == 6'h01) begin
              hs_ff <= H_TAIL;
            end else begin
              hs_ff <= H_LOW;
              sclk_ff <= 1'b0;
              mosi_ff <= htx_ff[15];
              htx_ff <= {htx_ff[14:0], 1'b0};
            end
          end
        end
        H_TAIL: begin
          if (dend) begin
            hs_ff <= H_IDLE;
            cs_n_ff <= 1'b1;
            done_ff <= 1'b1;
          end
        end
        default: hs_ff <= H_IDLE;
      endcase
    end
  end

  assign bvalid = bv_ff;
  assign bresp = br_ff;
  assign rvalid = rv_ff;
  assign rdata = rd_ff;
  assign rresp = rr_ff;
  assign irq = irq_ff;
  assign spi.sclk = sclk_ff;
  assign spi.cs_n = cs_n_ff;
  assign spi.sdi = mosi_ff;
  assign spi.hold_n = cfg_ff[0];
  assign spi.self_check_inputs = cfg_ff[2:1];

endmodule : gsr_host

// >>> sim/gsr_props.sv
// Concurrent checks on the serial link between both ends.
`timescale 1ns/1ps
module gsr_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic rdy_n,
  input wire logic hold_n,
  input wire logic [1:0] self_check_inputs,
  input wire logic self_test,
  input wire logic converting
);
  // ******************************************************
  // Frame bookkeeping
  // ******************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic sclk_ff;
  logic [5:0] nfall_ff;
  logic [5:0] nxt_nfall;
  // Falls are counted per frame, so a clipped byte shows.
  assign nxt_nfall = cs_n ? 6'h00 : nfall_ff + {5'h00, sclk_ff & ~sclk};
  always_ff @(posedge clock) begin
    sclk_ff <= sclk;
    nfall_ff <= nxt_nfall;
  end
  // ******************************************************
  // Assertions
  // ******************************************************
  // idle clock level.
  chk_idle_clock_high: assert property (cs_n |-> sclk)
    else $error("serial clock low outside a frame");
  chk_frame_lead_len: assert property ($fell(cs_n) |-> sclk[*8] ##1 !sclk)
    else $error("frame lead time wrong");
  chk_clock_low_len: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 sclk)
    else $error("serial clock low phase wrong");
  chk_frame_whole_bytes: assert property ($rose(cs_n) |-> nfall_ff != 6'h00 && nfall_ff[2:0] == 3'h0)
    else $error("frame is not whole bytes");
  chk_sdi_high_stable: assert property (!cs_n && !$past(cs_n) && sclk && sclk_ff |-> $stable(sdi))
    else $error("host data moved while clock high");
  chk_sdo_high_stable: assert property ($rose(sclk) && !cs_n |=> $stable(sdo)[*7])
    else $error("device data moved while clock high");
  chk_conv_runs: assert property (hold_n[*8] |-> converting)
    else $error("conversion not running with hold released");
  chk_self_test_on: assert property ((self_check_inputs == 2'h3)[*8] |-> self_test)
    else $error("self-test not entered");
  chk_self_test_off: assert property ((self_check_inputs != 2'h3)[*8] |-> !self_test)
    else $error("self-test active without all inputs high");
  cover property ($rose(cs_n) && nfall_ff == 6'h10);
  cover property ($rose(cs_n) && nfall_ff == 6'h20);
  cover property ($rose(self_test));
  cover property ($fell(rdy_n));
endmodule : gsr_props

// >>> sim/gsr_tb_top.sv
// Bench joining the controller and sensor ends over the link.
`timescale 1ns/1ps
module gsr_tb_top
  import gsr_pkg::*;
;
  // ******************************************************
  // Signals and ends
  // ******************************************************
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic self_test, converting;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb;
  logic [23:0] rate_in, temp_in;
  int n_errors, n_tests;
  localparam logic [5:0] ADRS [6] = '{ADR_PIN, ADR_GCS, ADR_TCS, ADR_GCT, ADR_TCT, ADR_RES};
  localparam logic [7:0] RSTV [6] = '{PIN_RST, CS_RST, CS_RST, CT_RST, CT_RST, RES_RST};
  localparam logic [7:0] CFGV [6] = '{8'h38, 8'h0A, 8'h0A, 8'h05, 8'h05, 8'h22};
  localparam logic [5:0] RSVD [6] = '{6'h02, 6'h07, 6'h10, 6'h22, 6'h33, 6'h37};
  gsr_spi_if spi();
  gsr_dev #(.CONV_CYC(50), .TEST_SHIFT(TEST_SHIFT_DEF)) u_gsr_dev (.clock(clock), .rst(rst), .spi(spi.dev), .rate_in(rate_in), .temp_in(temp_in), .self_test(self_test), .converting(converting));
  gsr_host #(.HALF(8)) u_gsr_host (.clock(clock), .rst(rst), .spi(spi.host), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
  gsr_props u_gsr_props (.clock(clock), .rst(rst), .sclk(spi.sclk), .cs_n(spi.cs_n), .sdi(spi.sdi), .sdo(spi.sdo), .rdy_n(spi.rdy_n), .hold_n(spi.hold_n), .self_check_inputs(spi.self_check_inputs), .self_test(self_test), .converting(converting));
  // ******************************************************
  // Tasks
  // ******************************************************
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task automatic tmo();
    n_errors++;
    end_of_test();
  endtask : tmo
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  // Pins are sampled mid-cycle, well clear of the edge.
  task automatic cmp_bit(input logic exp);
    @(negedge clock);
    cmp_val({31'h0, spi.rdy_n}, {31'h0, exp});
  endtask : cmp_bit
  // Handshakes seen at the falling edge hold at the next rise.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 100; i++) begin
      @(negedge clock);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid;
      rs = bresp;
      @(posedge clock);
      if (aw_hs) awvalid <= 1'h0;
      if (w_hs) wvalid <= 1'h0;
      if (b_hs) begin
        bready <= 1'h0;
        return;
      end
    end
    tmo();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ar_hs, r_hs;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 100; i++) begin
      @(negedge clock);
      ar_hs = arvalid & arready;
      r_hs = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clock);
      if (ar_hs) arvalid <= 1'h0;
      if (r_hs) begin
        rready <= 1'h0;
        return;
      end
    end
    tmo();
  endtask : axi_rd
  task automatic frame(input logic [7:0] c, input logic [7:0] w, input logic [1:0] n);
    axi_wr(A_CMD, {14'h0, n, w, c});
    for (int i = 0; i < 400; i++) begin
      axi_rd(A_STAT);
      if (rd[STAT_DONE] === 1'h1) begin
        axi_rd(A_RXD);
        return;
      end
    end
    tmo();
  endtask : frame
  task automatic wait_irq();
    for (int i = 0; i < 3000; i++) begin
      @(negedge clock);
      if (irq === 1'h1) return;
    end
    tmo();
  endtask : wait_irq
  // ******************************************************
  // Clock and sequence
  // ******************************************************
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  // Sensor inputs are fixed so every result code is known.
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    rate_in = 24'h001234;
    temp_in = 24'h0CE70C;
    n_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    axi_rd(A_CFG);
    cmp_val(rd, {29'h0, CFG_RST});
    axi_rd(8'h14);
    cmp_val({30'h0, rs}, {30'h0, RESP_ERR});
    for (int i = 0; i < 6; i++) begin
      frame({2'h1, ADRS[i]}, 8'h00, 2'h1);
      cmp_val({24'h0, rd[7:0]}, {24'h0, RSTV[i]});
      frame({2'h0, ADRS[i]}, CFGV[i], 2'h0);
      frame({2'h1, ADRS[i]}, 8'h00, 2'h1);
      cmp_val({24'h0, rd[7:0]}, {24'h0, CFGV[i]});
      frame({2'h0, RSVD[i]}, 8'hFF, 2'h0);
      frame({2'h1, RSVD[i]}, 8'h00, 2'h1);
      cmp_val({24'h0, rd[7:0]}, 32'h0);
    end
    frame(8'h40, 8'h00, 2'h1);
    cmp_val({24'h0, rd[7:0]}, 32'h0);
    frame(8'h81, 8'h00, 2'h0);
    frame(8'h41, 8'h00, 2'h1);
    cmp_val({24'h0, rd[7:0]}, 32'h38);
    frame(8'hC1, 8'h00, 2'h1);
    cmp_val({24'h0, rd[7:0]}, 32'h0);
    frame({2'h1, ADR_RATE}, 8'h00, 2'h3);
    cmp_val({8'h0, rd[23:0]}, {8'h0, MID_CODE + rate_in});
    cmp_bit(1'h1);
    axi_wr(A_MASK, 32'h2);
    wait_irq();
    cmp_bit(1'h0);
    axi_rd(A_STAT);
    cmp_val({31'h0, rd[STAT_RDY]}, 32'h1);
    repeat (3) @(posedge clock);
    cmp_val({31'h0, irq}, 32'h0);
    axi_wr(A_MASK, 32'h0);
    repeat (3) @(posedge clock);
    cmp_val({31'h0, irq}, 32'h0);
    frame({2'h1, ADR_TEMP}, 8'h00, 2'h3);
    cmp_val({8'h0, rd[23:0]}, 32'h8CE70C);
    axi_wr(A_CFG, 32'h7);
    repeat (300) @(posedge clock);
    frame({2'h1, ADR_RATE}, 8'h00, 2'h3);
    cmp_val({8'h0, rd[23:0]}, {8'h0, MID_CODE + rate_in + TEST_SHIFT_DEF});
    axi_wr(A_CFG, 32'h1);
    frame({2'h0, ADR_RES}, 8'h20, 2'h0);
    repeat (300) @(posedge clock);
    frame({2'h1, ADR_TEMP}, 8'h00, 2'h2);
    cmp_val({16'h0, rd[15:0]}, 32'h8CE7);
    frame({2'h0, ADR_TCS}, CS_RST, 2'h0);
    frame({2'h1, ADR_RATE}, 8'h00, 2'h2);
    repeat (300) @(posedge clock);
    cmp_bit(1'h1);
    frame({2'h0, ADR_PIN}, 8'h30, 2'h0);
    repeat (300) @(posedge clock);
    cmp_bit(1'h0);
    frame({2'h0, ADR_PIN}, 8'h31, 2'h0);
    axi_wr(A_CFG, 32'h0);
    repeat (20) @(posedge clock);
    cmp_val({31'h0, converting}, 32'h0);
    axi_wr(A_CFG, 32'h1);
    repeat (20) @(posedge clock);
    cmp_val({31'h0, converting}, 32'h1);
    end_of_test();
  end
endmodule : gsr_tb_top
